// file: dv/cpu_model.sv
// CPU-side partner model driving condition code, service and stop strobes
`timescale 1ns/10ps
module cpu_model (
  input wire logic ref_clk_i,
  output logic i_mask_o,
  output logic [7:0] ccr_o,
  output logic ccr_write_o,
  output logic [7:0] ccr_write_data_o,
  output logic nonmaskable_ack_o,
  output logic resolve_o,
  output logic return_from_interrupt_o,
  output logic stop_mode_o
);
  initial begin
    i_mask_o = 1'b1;
    ccr_o = 8'hff;
    ccr_write_data_o = 8'h00;
    stop_mode_o = 1'b0;
    {ccr_write_o, nonmaskable_ack_o, resolve_o, return_from_interrupt_o} = 4'h0;
  end
  // One-cycle strobes: write, acknowledge, resolve, return
  task automatic strobe(input logic [3:0] s, input logic [7:0] d);
    @(posedge ref_clk_i);
    ccr_write_data_o <= d;
    {ccr_write_o, nonmaskable_ack_o, resolve_o, return_from_interrupt_o} <= s;
    @(posedge ref_clk_i);
    {ccr_write_o, nonmaskable_ack_o, resolve_o, return_from_interrupt_o} <= 4'h0;
  endtask
  task automatic level(input logic i, input logic stop);
    @(posedge ref_clk_i);
    i_mask_o <= i;
    stop_mode_o <= stop;
  endtask
endmodule

// file: dv/intr_prio_ctrl_tb.sv
// Self-checking bench for the interrupt priority and mode control block
`timescale 1ns/10ps
module intr_prio_ctrl_tb;
  import intr_prio_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb, grant_source_o, pull_index_o;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, strap_special_i, strap_mode_a_i;
  logic i_mask_i, ccr_write_i, nonmaskable_ack_i, nonmaskable_request_n_i, ext_request_n_i;
  logic resolve_i, return_from_interrupt_i, stop_mode_i, internal_read_i, x_mask_o;
  logic grant_valid_o, grant_nonmaskable_o, grant_maskable_o, pull_active_o, pull_last_o;
  logic wake_o, wake_service_o, boot_rom_hit_o, ext_data_oe_o;
  logic [7:0] cpu_ccr_i, ccr_write_data_i, internal_rdata_i, stack_ccr_o, ext_data_o;
  logic [15:0] source_req_i, cpu_addr_i;
  logic [39:0] exp_r[$], exp_m[$], exp_b[$], exp_g[$], exp_p[$], exp_w[$];
  logic [31:0] seed = 32'h0000e9c7;
  int n_errors = 0;
  int checked = 0;
  always #25 ref_clk_i = ~ref_clk_i;
  intr_prio_ctrl u_intr_prio_ctrl (.*);
  cpu_model u_cpu_model (.ref_clk_i(ref_clk_i), .i_mask_o(i_mask_i), .ccr_o(cpu_ccr_i),
    .ccr_write_o(ccr_write_i), .ccr_write_data_o(ccr_write_data_i), .nonmaskable_ack_o(nonmaskable_ack_i),
    .resolve_o(resolve_i), .return_from_interrupt_o(return_from_interrupt_i), .stop_mode_o(stop_mode_i));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic void chk(string nm, logic [39:0] e, logic [39:0] s);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endfunction
  function automatic logic [39:0] pop(ref logic [39:0] q[$]);
    if (q.size() == 0) return 40'hxxxxxxxxxx;
    return q.pop_front();
  endfunction
  task automatic summarize();
    chk("pending", 40'h0, 40'(exp_r.size() + exp_b.size() + exp_g.size() + exp_p.size() + exp_w.size()));
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Result monitor
  // ----------------------------------------
  always @(negedge ref_clk_i) begin
    if (s_axi_rvalid && s_axi_rready) chk("rdata", pop(exp_r), {s_axi_rresp, s_axi_rdata} & pop(exp_m));
    if (s_axi_bvalid && s_axi_bready) chk("bresp", pop(exp_b), 40'(s_axi_bresp));
    if (grant_valid_o) chk("grant", pop(exp_g), 40'({grant_nonmaskable_o, grant_maskable_o, grant_source_o}));
    if (pull_active_o) chk("pull", pop(exp_p), 40'({pull_last_o, pull_index_o}));
    if (wake_o) chk("wake", pop(exp_w), 40'(wake_service_o));
  end
  // ----------------------------------------
  // Bus and pin tasks
  // ----------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r);
    int n = 0;
    exp_b.push_back(40'(r));
    @(posedge ref_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= (rnd() & 32'hffffff00) | 32'(d);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge ref_clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] r);
    int n = 0;
    exp_r.push_back(40'({r, e}));
    exp_m.push_back({8'h03, m});
    @(posedge ref_clk_i);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge ref_clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'b0;
  endtask
  task automatic wc(input logic [7:0] d);
    wr(4'h0, d, 2'h0);
  endtask
  task automatic rc(input logic [7:0] e);
    rd(4'h0, 32'(e), 32'hff, 2'h0);
  endtask
  task automatic rx(input logic e);
    rd(4'h4, 32'(e) << 2, 32'h4, 2'h0);
  endtask
  task automatic rom(input logic [15:0] a, input logic e);
    @(posedge ref_clk_i);
    cpu_addr_i <= a;
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk("rom_hit", 40'(e), 40'(boot_rom_hit_o));
  endtask
  task automatic vis(input logic e);
    logic [7:0] d;
    d = 8'(rnd());
    @(posedge ref_clk_i);
    internal_read_i <= 1'b1;
    internal_rdata_i <= d;
    @(posedge ref_clk_i);
    internal_read_i <= 1'b0;
    @(negedge ref_clk_i);
    chk("ext_data", {31'h0, e, e ? d : 8'h00}, 40'({ext_data_oe_o, ext_data_o}));
  endtask
  task automatic wake(input logic nm, input logic e);
    int n = 0;
    exp_w.push_back(40'(e));
    u_cpu_model.level(nm, 1'b1);
    nonmaskable_request_n_i <= !nm;
    ext_request_n_i <= nm;
    while (!wake_o && n < 20) begin
      @(negedge ref_clk_i);
      n++;
    end
    u_cpu_model.level(1'b1, 1'b0);
    {nonmaskable_request_n_i, ext_request_n_i} <= 2'h3;
  endtask
  task automatic reset(input logic md);
    @(posedge ref_clk_i);
    rst_n_i <= 1'b0;
    strap_mode_a_i <= md;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    int p;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = {8'h00, 4'h1, 32'h0};
    {strap_special_i, strap_mode_a_i, nonmaskable_request_n_i, ext_request_n_i} = 4'hb;
    {source_req_i, cpu_addr_i, internal_read_i, internal_rdata_i} = 41'h0;
    reset(1'b1);
    rc(8'h66);
    rx(1'b1);
    wc(8'he6);
    rc(8'he6);
    rom(16'hbf40, 1'b0);
    reset(1'b0);
    rc(8'hc6);
    rom(16'hbf40, 1'b1);
    rom(16'hbfff, 1'b1);
    rom(16'hbf3f, 1'b0);
    wc(8'hd6);
    rc(8'hd6);
    vis(1'b1);
    wc(8'h36);
    rc(8'h26);
    vis(1'b0);
    rom(16'hbf40, 1'b0);
    wc(8'hf1);
    rc(8'h21);
    u_cpu_model.level(1'b0, 1'b0);
    wc(8'h22);
    rc(8'h21);
    u_cpu_model.level(1'b1, 1'b0);
    wr(4'hc, 8'h00, 2'h2);
    rd(4'hc, 32'h0, 32'hffffffff, 2'h2);
    for (int c = 0; c < 17; c++) begin
      p = (c == 5) ? 6 : c;
      if (c < 16) wc(8'(c));
      @(posedge ref_clk_i);
      source_req_i <= (c == 16) ? 16'h0 : (16'(rnd()) & 16'hffdf) | (16'h1 << p);
      exp_g.push_back((c == 16) ? 40'h0 : 40'({2'b01, 4'(p)}));
      u_cpu_model.strobe(4'b0010, 8'h00);
    end
    wake(1'b1, 1'b0);
    wake(1'b0, 1'b0);
    u_cpu_model.strobe(4'b1000, 8'h40);
    rx(1'b1);
    u_cpu_model.strobe(4'b1000, 8'hbf);
    rx(1'b0);
    wake(1'b1, 1'b1);
    @(posedge ref_clk_i);
    nonmaskable_request_n_i <= 1'b0;
    source_req_i <= 16'hffdf;
    exp_g.push_back(40'h20);
    u_cpu_model.strobe(4'b0010, 8'h00);
    nonmaskable_request_n_i <= 1'b1;
    u_cpu_model.strobe(4'b0100, 8'h00);
    @(negedge ref_clk_i);
    chk("stack_ccr", 40'h1bf, 40'({x_mask_o, stack_ccr_o}));
    u_cpu_model.strobe(4'b1000, 8'h00);
    u_cpu_model.strobe(4'b1100, 8'h00);
    @(negedge ref_clk_i);
    chk("x_mask", 40'h1, 40'(x_mask_o));
    for (int i = 0; i < 9; i++) exp_p.push_back(40'({i == 8, 4'(i)}));
    u_cpu_model.strobe(4'b0001, 8'h00);
    u_cpu_model.strobe(4'b0001, 8'h00);
    repeat (12) @(posedge ref_clk_i);
    summarize();
  end
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    n_errors++;
    summarize();
  end
endmodule

// file: logic/intr_prio_ctrl.sv
// Interrupt priority, mode control, X mask and stop wake-up logic
`timescale 1ns/10ps
// Function
// - Boot ROM enable maps 192-byte ROM window
// - Boot ROM only present in special bootstrap mode
// - Boot ROM bit writable to 1 in test
// - Special latch clears only, never sets again
// - Mode-A select writable only while special latch
// - Read visibility writable in special, else zero
// - Visibility drives internal read data onto bus
// - Priority select writable only while I set
// - Codes 0-7 pick timer through real-time sources
// - Codes 8-15 pick captures then compares
// - Reserved code 0101 acts as external request
// - Promoted source tops maskables, below nonmaskable
// - Return unstacks all registers, PC last
// - X clears only by code transfer or unstack
// - X set by reset or nonmaskable acknowledge
// - X clears only when written bit 6 zero
// - Stack condition code with X clear, then set
// - Stop wakes on reset, IRQ or nonmaskable
// - Nonmaskable wake with X clear leads to service
// - Wake with X set continues after stop
// - Register readable always, high nibble special only
// - Nonmaskable request outranks all maskable sources
// - Resolution samples requests after code stacked
// - Promotion keeps vector and masking unchanged
module intr_prio_ctrl (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [intr_prio_pkg::addr_width-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [intr_prio_pkg::data_width-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [intr_prio_pkg::addr_width-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [intr_prio_pkg::data_width-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic strap_special_i,
  input wire logic strap_mode_a_i,
  input wire logic i_mask_i,
  input wire logic [7:0] cpu_ccr_i,
  input wire logic ccr_write_i,
  input wire logic [7:0] ccr_write_data_i,
  input wire logic nonmaskable_ack_i,
  input wire logic nonmaskable_request_n_i,
  input wire logic ext_request_n_i,
  input wire logic [intr_prio_pkg::num_sources-1:0] source_req_i,
  input wire logic resolve_i,
  input wire logic return_from_interrupt_i,
  input wire logic stop_mode_i,
  input wire logic [15:0] cpu_addr_i,
  input wire logic internal_read_i,
  input wire logic [7:0] internal_rdata_i,
  output logic x_mask_o,
  output logic [7:0] stack_ccr_o,
  output logic grant_valid_o,
  output logic grant_nonmaskable_o,
  output logic grant_maskable_o,
  output logic [3:0] grant_source_o,
  output logic pull_active_o,
  output logic [3:0] pull_index_o,
  output logic pull_last_o,
  output logic wake_o,
  output logic wake_service_o,
  output logic boot_rom_hit_o,
  output logic ext_data_oe_o,
  output logic [7:0] ext_data_o
);
  import intr_prio_pkg::*;

  // -------------------------------------------------------------
  // Priority helpers
  // -------------------------------------------------------------
  function automatic logic [3:0] promoted_code(input logic [3:0] sel);
    promoted_code = (sel == reserved_code) ? ext_request_code : sel;
  endfunction

  function automatic logic [4:0] pick_maskable(input logic [num_sources-1:0] req, input logic [3:0] sel);
    logic [3:0] code;
    code = promoted_code(sel);
    pick_maskable = 5'h00;
    if (req[code]) begin
      pick_maskable = {1'b1, code};
    end else begin
      for (int k = num_sources - 1; k >= 0; k--) begin
        if (req[k]) begin
          pick_maskable = {1'b1, 4'(k)};
        end
      end
    end
  endfunction

  // -------------------------------------------------------------
  // Strap capture and control register state
  // -------------------------------------------------------------
  logic captured, next_captured;
  logic boot_rom_enable, next_boot_rom_enable;
  logic special_mode_latch, next_special_mode_latch;
  logic mode_a_select, next_mode_a_select;
  logic internal_read_visibility, next_internal_read_visibility;
  logic [3:0] promoted_source_select, next_promoted_source_select;
  logic [7:0] priority_and_misc_control;
  logic do_write;
  logic [addr_width-1:0] wr_addr;
  logic [data_width-1:0] wr_data;
  logic [3:0] wr_strb;

  assign priority_and_misc_control = {boot_rom_enable, special_mode_latch, mode_a_select,
                                      internal_read_visibility, promoted_source_select};

  always_comb begin
    next_captured = 1'b1;
    next_boot_rom_enable = boot_rom_enable;
    next_special_mode_latch = special_mode_latch;
    next_mode_a_select = mode_a_select;
    next_internal_read_visibility = internal_read_visibility;
    next_promoted_source_select = promoted_source_select;
    if (!captured) begin
      next_special_mode_latch = strap_special_i;
      next_mode_a_select = strap_mode_a_i;
      next_boot_rom_enable = strap_special_i & ~strap_mode_a_i;
    end else if (do_write && wr_addr == prio_ctrl_offset && wr_strb[0]) begin
      if (special_mode_latch) begin
        next_boot_rom_enable = wr_data[boot_rom_enable_bit];
        next_mode_a_select = wr_data[mode_a_select_bit];
        next_internal_read_visibility = wr_data[internal_read_visibility_bit];
      end
      if (!wr_data[special_mode_latch_bit]) begin
        next_special_mode_latch = 1'b0;
      end
      if (i_mask_i) begin
        next_promoted_source_select = wr_data[promoted_source_select_lsb +: 4];
      end
    end
    if (!next_special_mode_latch) begin
      next_internal_read_visibility = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      captured <= 1'b0;
      boot_rom_enable <= 1'b0;
      special_mode_latch <= 1'b0;
      mode_a_select <= 1'b0;
      internal_read_visibility <= 1'b0;
      promoted_source_select <= promoted_source_reset;
    end else begin
      captured <= next_captured;
      boot_rom_enable <= next_boot_rom_enable;
      special_mode_latch <= next_special_mode_latch;
      mode_a_select <= next_mode_a_select;
      internal_read_visibility <= next_internal_read_visibility;
      promoted_source_select <= next_promoted_source_select;
    end
  end

  // -------------------------------------------------------------
  // X mask flip-flop, stacking and priority resolution
  // -------------------------------------------------------------
  logic next_x_mask;
  logic [7:0] next_stack_ccr;
  logic next_grant_valid, next_grant_nonmaskable, next_grant_maskable;
  logic [3:0] next_grant_source;
  logic [4:0] pick;
  logic nonmaskable_pending;

  assign nonmaskable_pending = ~nonmaskable_request_n_i & ~x_mask_o;

  always_comb begin
    next_x_mask = x_mask_o;
    if (nonmaskable_ack_i) begin
      next_x_mask = 1'b1;
    end else if (ccr_write_i && !ccr_write_data_i[x_mask_bit]) begin
      next_x_mask = 1'b0;
    end
    next_stack_ccr = cpu_ccr_i;
    next_stack_ccr[x_mask_bit] = x_mask_o;
    pick = pick_maskable(source_req_i, promoted_source_select);
    next_grant_valid = resolve_i;
    next_grant_nonmaskable = resolve_i & nonmaskable_pending;
    next_grant_maskable = resolve_i & ~nonmaskable_pending & pick[4];
    next_grant_source = (resolve_i && !nonmaskable_pending) ? pick[3:0] : 4'h0;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      x_mask_o <= 1'b1;
      stack_ccr_o <= 8'h00;
      grant_valid_o <= 1'b0;
      grant_nonmaskable_o <= 1'b0;
      grant_maskable_o <= 1'b0;
      grant_source_o <= 4'h0;
    end else begin
      x_mask_o <= next_x_mask;
      stack_ccr_o <= next_stack_ccr;
      grant_valid_o <= next_grant_valid;
      grant_nonmaskable_o <= next_grant_nonmaskable;
      grant_maskable_o <= next_grant_maskable;
      grant_source_o <= next_grant_source;
    end
  end

  // -------------------------------------------------------------
  // Return unstacking sequence: condition code first, PC bytes last
  // -------------------------------------------------------------
  pull_state_type pull_state, next_pull_state;
  logic next_pull_active, next_pull_last;
  logic [3:0] next_pull_index;

  always_comb begin
    next_pull_state = pull_state;
    next_pull_active = 1'b0;
    next_pull_last = 1'b0;
    next_pull_index = pull_index_o;
    unique case (pull_state)
      pull_idle: begin
        next_pull_index = 4'h0;
        if (return_from_interrupt_i) begin
          next_pull_state = pull_run;
          next_pull_active = 1'b1;
        end
      end
      pull_run: begin
        next_pull_active = 1'b1;
        next_pull_index = pull_index_o + 4'h1;
        next_pull_last = (next_pull_index == pull_count - 4'h1);
        if (pull_last_o) begin
          next_pull_state = pull_idle;
          next_pull_active = 1'b0;
          next_pull_index = 4'h0;
          next_pull_last = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pull_state <= pull_idle;
      pull_active_o <= 1'b0;
      pull_index_o <= 4'h0;
      pull_last_o <= 1'b0;
    end else begin
      pull_state <= next_pull_state;
      pull_active_o <= next_pull_active;
      pull_index_o <= next_pull_index;
      pull_last_o <= next_pull_last;
    end
  end

  // -------------------------------------------------------------
  // Stop wake-up, boot ROM decode, read visibility
  // -------------------------------------------------------------
  logic next_wake, next_wake_service, next_boot_rom_hit, next_ext_data_oe;
  logic [7:0] next_ext_data;
  logic wake_cause;

  assign wake_cause = ~nonmaskable_request_n_i | ~ext_request_n_i;

  always_comb begin
    next_wake = stop_mode_i & wake_cause & ~wake_o;
    next_wake_service = stop_mode_i & ~wake_o & ~nonmaskable_request_n_i & ~x_mask_o;
    next_boot_rom_hit = boot_rom_enable & special_mode_latch & ~mode_a_select
                        & (cpu_addr_i >= boot_rom_base)
                        & (cpu_addr_i - boot_rom_base < boot_rom_bytes);
    next_ext_data_oe = internal_read_visibility & internal_read_i;
    next_ext_data = next_ext_data_oe ? internal_rdata_i : 8'h00;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wake_o <= 1'b0;
      wake_service_o <= 1'b0;
      boot_rom_hit_o <= 1'b0;
      ext_data_oe_o <= 1'b0;
      ext_data_o <= 8'h00;
    end else begin
      wake_o <= next_wake;
      wake_service_o <= next_wake_service;
      boot_rom_hit_o <= next_boot_rom_hit;
      ext_data_oe_o <= next_ext_data_oe;
      ext_data_o <= next_ext_data;
    end
  end

  // -------------------------------------------------------------
  // AXI4-Lite slave
  // -------------------------------------------------------------
  logic aw_held, w_held, next_aw_held, next_w_held;
  logic [addr_width-1:0] next_wr_addr;
  logic [data_width-1:0] next_wr_data, next_rdata;
  logic [3:0] next_wr_strb;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;

  function automatic logic mapped(input logic [addr_width-1:0] a);
    mapped = (a == prio_ctrl_offset) || (a == status_offset) || (a == ctrl_offset);
  endfunction

  assign do_write = aw_held & w_held & ~s_axi_bvalid;

  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_wr_strb = wr_strb;
    next_bvalid = s_axi_bvalid & ~s_axi_bready;
    next_bresp = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_wr_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_wr_data = s_axi_wdata;
      next_wr_strb = s_axi_wstrb;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = mapped(wr_addr) ? axi_okay : axi_slverr;
    end
    next_awready = ~next_aw_held & ~next_bvalid;
    next_wready = ~next_w_held & ~next_bvalid;
    next_rvalid = s_axi_rvalid & ~s_axi_rready;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = mapped(s_axi_araddr) ? axi_okay : axi_slverr;
      unique case (s_axi_araddr)
        prio_ctrl_offset: next_rdata = {24'h000000, priority_and_misc_control};
        status_offset: next_rdata = {24'h000000, 2'h0, pull_active_o, stop_mode_i,
                                     i_mask_i, x_mask_o, grant_nonmaskable_o, grant_maskable_o};
        ctrl_offset: next_rdata = {27'h0000000, grant_valid_o, grant_source_o};
        default: next_rdata = 32'h00000000;
      endcase
    end
    next_arready = ~next_rvalid;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      wr_strb <= next_wr_strb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  // -------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence ccr_clear_write;
    ccr_write_i && !ccr_write_data_i[x_mask_bit] && !nonmaskable_ack_i;
  endsequence

  sequence pull_start;
    return_from_interrupt_i && pull_state == pull_idle;
  endsequence

  AST_X_SET_BY_ACK: assert property (nonmaskable_ack_i |=> x_mask_o)
    else $error("X mask not set after acknowledge");
  AST_X_CLEAR: assert property (ccr_clear_write |=> !x_mask_o)
    else $error("X mask not cleared by zero write");
  AST_X_NO_SW_SET: assert property (!x_mask_o && !nonmaskable_ack_i |=> !x_mask_o)
    else $error("X mask set without acknowledge");
  AST_SPECIAL_MODE_LATCH_STICKY: assert property (captured && !special_mode_latch |=> !special_mode_latch)
    else $error("Special latch set again");
  AST_IRV_FORCED: assert property (!special_mode_latch |-> !internal_read_visibility)
    else $error("Visibility set outside special mode");
  AST_PSEL_GUARD: assert property (captured && !i_mask_i |=> $stable(promoted_source_select))
    else $error("Priority select changed with I clear");
  AST_NMI_FIRST: assert property (resolve_i && nonmaskable_pending |=> grant_nonmaskable_o && !grant_maskable_o)
    else $error("Nonmaskable request not granted first");
  AST_PROMOTED: assert property (resolve_i && !nonmaskable_pending && source_req_i[promoted_code(promoted_source_select)]
                                 |=> grant_maskable_o && grant_source_o == $past(promoted_code(promoted_source_select)))
    else $error("Promoted source not granted");
  AST_PULL_LEN: assert property (pull_start |=> pull_active_o [*8] ##1 pull_last_o && pull_index_o == 4'h8)
    else $error("Unstack sequence length wrong");
  AST_WAKE_CONT: assert property (stop_mode_i && !wake_o && !nonmaskable_request_n_i && x_mask_o
                                  |=> wake_o && !wake_service_o)
    else $error("Wake with X set must not service");
  AST_ROM_MODE: assert property (boot_rom_hit_o |-> $past(special_mode_latch) && !$past(mode_a_select))
    else $error("Boot ROM visible outside bootstrap");
endmodule

// file: logic/intr_prio_pkg.sv
// Constants for the interrupt priority and mode control block
package intr_prio_pkg;
  // -------------------------------------------------------------
  // Register map
  // -------------------------------------------------------------
  localparam logic [3:0] prio_ctrl_offset = 4'h0;
  localparam logic [3:0] status_offset = 4'h4;
  localparam logic [3:0] ctrl_offset = 4'h8;
  localparam int addr_width = 4;
  localparam int data_width = 32;
  // -------------------------------------------------------------
  // Fields of priority_and_misc_control
  // -------------------------------------------------------------
  localparam int boot_rom_enable_bit = 7;
  localparam int special_mode_latch_bit = 6;
  localparam int mode_a_select_bit = 5;
  localparam int internal_read_visibility_bit = 4;
  localparam int promoted_source_select_lsb = 0;
  localparam logic [3:0] promoted_source_reset = 4'h6;
  // -------------------------------------------------------------
  // Condition code and maskable sources
  // -------------------------------------------------------------
  localparam int x_mask_bit = 6;
  localparam int num_sources = 16;
  localparam logic [3:0] reserved_code = 4'h5;
  localparam logic [3:0] ext_request_code = 4'h6;
  // -------------------------------------------------------------
  // Bootstrap ROM window and unstacking
  // -------------------------------------------------------------
  localparam logic [15:0] boot_rom_base = 16'hbf40;
  localparam logic [15:0] boot_rom_bytes = 16'h00c0;
  localparam logic [3:0] pull_count = 4'h9;
  localparam logic [1:0] axi_okay = 2'h0;
  localparam logic [1:0] axi_slverr = 2'h2;
  typedef enum logic [1:0] {pull_idle, pull_run} pull_state_type;
endpackage
